// ===== common/dnvr_regs.svh
// Purpose: offsets, reset values, field positions and timing figures of
//          the dual resistor serial slave
// Assumes: byte offsets on the serial bus, one byte per location
// Notes:   times are kept in ns and turned into cycles where they are used
`ifndef DNVR_REGS_SVH
`define DNVR_REGS_SVH

// memory map offsets
`define DNVR_OFF_BUS_ADDR   8'h00
`define DNVR_OFF_HIZ_CTRL   8'h01
`define DNVR_OFF_RES_ZERO   8'h02
`define DNVR_OFF_RES_ONE    8'h03
`define DNVR_OFF_ENTRY_HI   8'h04
`define DNVR_OFF_ENTRY_LO   8'h05
`define DNVR_OFF_KEY_HI     8'h06
`define DNVR_OFF_KEY_LO     8'h07
`define DNVR_OFF_GAP_LO     8'h08
`define DNVR_OFF_GAP_HI     8'h0F
`define DNVR_OFF_USER_LO    8'h10
`define DNVR_OFF_USER_HI    8'h1F

// factory and power-up values
`define DNVR_RST_BUS_ADDR   8'hA0
`define DNVR_RST_HIZ_CTRL   8'h00
`define DNVR_RST_RES        8'h7F
`define DNVR_RST_ENTRY      16'hFFFF
`define DNVR_RST_KEY        8'hFF
`define DNVR_RST_USER       8'hFF
`define DNVR_RD_NONE        8'hFF

// fixed slave address byte used while address select is low
`define DNVR_FIXED_ADDR     8'hA2

// high-impedance control fields
`define DNVR_BIT_FLOAT_ZERO 0
`define DNVR_BIT_FLOAT_ONE  1

// timing
`define DNVR_CLK_NS         4
`define DNVR_T_WR_NS        10000000
`define DNVR_T_ST_NS        2000000

`endif

// ===== common/dnvr_pkg.sv
// Purpose: shared types of the dual resistor serial slave
// Assumes: 32 byte image covers every mapped location
// Notes:   constants live in dnvr_regs.svh
package dnvr_pkg;

  typedef logic [31:0][7:0] dnvr_image_t;

  typedef enum logic [1:0] {
    OP_ADDR, OP_WRITE, OP_READ, OP_STOP
  } dnvr_op_t;

  typedef enum logic [2:0] {
    LS_IDLE, LS_RX, LS_ACK_GO, LS_ACK_OUT, LS_TX, LS_ACK_IN, LS_LOAD
  } dnvr_lst_t;

  typedef enum logic [1:0] {
    BK_ADDR, BK_MEM, BK_DATA
  } dnvr_kind_t;

  typedef struct packed {
    dnvr_lst_t  st;
    dnvr_kind_t kind;
    logic [3:0] bitc;
    logic [7:0] shift;
    logic       rd;
    logic       wr_act;
    logic [7:0] ptr;
    logic       oe_n;
    logic       lvl;
    logic       scl_p;
    logic       sda_p;
    logic       req_tgl;
    dnvr_op_t   req_op;
    logic [7:0] req_addr;
    logic [7:0] req_data;
    logic       ack_seen;
    logic       rsp_ack;
    logic [7:0] rsp_data;
  } dnvr_link_t;

  typedef struct packed {
    logic        req_seen;
    logic        ack_tgl;
    logic        rsp_ack;
    logic [7:0]  rsp_data;
    logic [15:0] entry;
    logic [1:0]  pend;
    logic [3:0]  row;
    logic [15:0] pdata;
    logic        wr_go;
    logic [1:0]  wmask;
    logic [7:0]  pos_zero;
    logic [7:0]  pos_one;
    logic        hiz_zero;
    logic        hiz_one;
  } dnvr_core_t;

  typedef struct packed {
    dnvr_image_t live;
    logic [31:0] cnt;
    logic        recall;
    logic        busy;
  } dnvr_nvm_t;

endpackage

// ===== hdl/dnvr_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: inputs are levels or toggles, never single-cycle pulses
// Notes:   the first stage is read by the second stage only
`timescale 1ns/1ns
module dnvr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  always_comb begin
    meta_d = d_i;
    out_d  = meta_q;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      out_q  <= '0;
    end else begin
      meta_q <= meta_d;
      out_q  <= out_d;
    end
  end

  assign q_o = out_q;
endmodule

// ===== hdl/dnvr_nvm.sv
// Purpose: nonvolatile image with power-up recall and timed page write
// Assumes: cells keep their contents across reset; no reset on them
// Notes:   live copy shows new bytes at once, busy covers the write time
`timescale 1ns/1ns
`include "dnvr_regs.svh"
module dnvr_nvm #(
  parameter int T_WR_CYC = 2500000,
  parameter int T_ST_CYC = 500000
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // page write
  input  wire logic                 wr_go_i,
  input  wire logic [3:0]           wr_row_i,
  input  wire logic [1:0]           wr_mask_i,
  input  wire logic [15:0]          wr_data_i,
  // state
  output dnvr_pkg::dnvr_image_t     live_o,
  output logic                      busy_o,
  output logic                      recall_o
);
  import dnvr_pkg::*;

  if (T_WR_CYC < 1 || T_ST_CYC < 1) begin : g_chk
    $error("nvm timing counts must be at least one cycle");
  end

  localparam logic [31:0] ST_LAST = 32'(T_ST_CYC - 1);
  localparam logic [31:0] WR_LAST = 32'(T_WR_CYC - 1);

  // factory contents; cells model storage that outlives reset
  localparam dnvr_image_t FACTORY = {{28{`DNVR_RST_USER}}, `DNVR_RST_RES,
                                     `DNVR_RST_RES, `DNVR_RST_HIZ_CTRL,
                                     `DNVR_RST_BUS_ADDR};

  dnvr_image_t cells = FACTORY;
  dnvr_nvm_t   s_q;
  dnvr_nvm_t   s_d;

  always_ff @(posedge clk_i) begin
    for (int b = 0; b < 2; b++) begin
      if (wr_go_i && wr_mask_i[b]) begin
        cells[{wr_row_i, b[0]}] <= wr_data_i[8*b +: 8];
      end
    end
  end

  always_comb begin
    s_d = s_q;
    if (s_q.cnt != 32'h0) begin
      s_d.cnt = s_q.cnt - 32'h1;
    end
    if (s_q.recall && s_q.cnt == 32'h0) begin
      s_d.recall = 1'b0;
      for (int i = 0; i < 32; i++) begin
        s_d.live[i] = cells[i];
      end
    end
    if (s_q.busy && s_q.cnt == 32'h0) begin
      s_d.busy = 1'b0;
    end
    if (wr_go_i) begin
      s_d.busy = 1'b1;
      s_d.cnt  = WR_LAST;
      for (int b = 0; b < 2; b++) begin
        if (wr_mask_i[b]) begin
          s_d.live[{wr_row_i, b[0]}] = wr_data_i[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q.live   <= '1;
      s_q.cnt    <= ST_LAST;
      s_q.recall <= 1'b1;
      s_q.busy   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign live_o   = s_q.live;
  assign busy_o   = s_q.busy;
  assign recall_o = s_q.recall;
endmodule

// ===== hdl/dnvr_top.sv
// Purpose: serial slave, memory map and resistor settings of a dual
//          digitally set resistor
// Assumes: link_clk_i samples the bus pins many times per bit; the
//          register core answers a request well inside half a bit
// Notes:   bus side runs on link_clk_i, memory side on clk_i; requests
//          cross by toggle handshake with held data
`timescale 1ns/1ns
`include "dnvr_regs.svh"
module dnvr_top #(
  parameter int T_WR_CYC = `DNVR_T_WR_NS / `DNVR_CLK_NS,
  parameter int T_ST_CYC = `DNVR_T_ST_NS / `DNVR_CLK_NS
) (
  // memory side clock and power-up reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // serial bus
  input  wire logic       link_clk_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  // address select pin
  input  wire logic       add_sel_i,
  // resistor controls
  output logic [7:0]      wiper_zero_pos_o,
  output logic [7:0]      wiper_one_pos_o,
  output logic            wiper_zero_hiz_o,
  output logic            wiper_one_hiz_o
);
  import dnvr_pkg::*;

  if (T_WR_CYC < 1 || T_ST_CYC < 1) begin : g_chk
    $error("timing counts must be at least one cycle");
  end

  dnvr_link_t  l_q;
  dnvr_link_t  l_d;
  dnvr_core_t  c_q;
  dnvr_core_t  c_d;
  logic [1:0]  pins_s;
  logic        ack_s;
  logic [1:0]  core_s;
  dnvr_image_t live;
  logic        nv_busy;
  logic        recalling;

  // locations backed by nonvolatile cells
  function automatic logic is_nv(input logic [7:0] a);
    logic gap;
    gap = (a >= `DNVR_OFF_ENTRY_HI) && (a <= `DNVR_OFF_ENTRY_LO);
    gap = gap || ((a >= `DNVR_OFF_GAP_LO) && (a <= `DNVR_OFF_GAP_HI));
    return (a <= `DNVR_OFF_USER_HI) && !gap;
  endfunction

  // read view: write-only and empty locations read as all ones
  function automatic logic [7:0] rd_byte(input logic [7:0]  a,
                                         input dnvr_image_t img,
                                         input logic        unl);
    logic key;
    key = (a == `DNVR_OFF_KEY_HI) || (a == `DNVR_OFF_KEY_LO);
    if (!is_nv(a) || (key && !unl)) begin
      return `DNVR_RD_NONE;
    end
    return img[a[4:0]];
  endfunction

  function automatic dnvr_link_t issue(input dnvr_link_t s,
                                       input dnvr_op_t   op,
                                       input logic [7:0] a,
                                       input logic [7:0] d);
    dnvr_link_t r;
    r          = s;
    r.req_tgl  = ~s.req_tgl;
    r.req_op   = op;
    r.req_addr = a;
    r.req_data = d;
    return r;
  endfunction

  // link domain
  // pins pass inverted so the synchroniser's zero reset means an idle
  // high bus; otherwise a false clock edge would follow every reset
  dnvr_sync #(.W(2)) u_pin_sync (
    .clk_i (link_clk_i),
    .rst_i (rst_i),
    .d_i   ({~scl_i, ~sda_i}),
    .q_o   (pins_s)
  );

  dnvr_sync #(.W(1)) u_ack_sync (
    .clk_i (link_clk_i),
    .rst_i (rst_i),
    .d_i   (c_q.ack_tgl),
    .q_o   (ack_s)
  );

  always_comb begin
    logic       scl_s;
    logic       sda_s;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [7:0] byt;
    scl_s   = ~pins_s[1];
    sda_s   = ~pins_s[0];
    rise    = scl_s && !l_q.scl_p;
    fall    = !scl_s && l_q.scl_p;
    start   = l_q.scl_p && scl_s && l_q.sda_p && !sda_s;
    stop    = l_q.scl_p && scl_s && !l_q.sda_p && sda_s;
    byt     = {l_q.shift[6:0], sda_s};
    l_d     = l_q;
    l_d.scl_p = scl_s;
    l_d.sda_p = sda_s;
    // response words were held stable before the toggle came back
    if (ack_s != l_q.ack_seen) begin
      l_d.ack_seen = ack_s;
      l_d.rsp_ack  = c_q.rsp_ack;
      l_d.rsp_data = c_q.rsp_data;
    end
    if (start) begin
      // a repeated start keeps the write flag so the page still commits
      l_d.st   = LS_RX;
      l_d.kind = BK_ADDR;
      l_d.bitc = 4'h0;
      l_d.oe_n = 1'b1;
    end else if (stop) begin
      if (l_q.wr_act) begin
        l_d = issue(l_d, OP_STOP, l_q.ptr, 8'h00);
      end
      l_d.wr_act = 1'b0;
      l_d.st     = LS_IDLE;
      l_d.oe_n   = 1'b1;
    end else begin
      unique case (l_q.st)
        LS_IDLE: begin
          l_d.oe_n = 1'b1;
        end
        LS_RX: begin
          if (rise) begin
            l_d.shift = byt;
            l_d.bitc  = l_q.bitc + 4'h1;
            if (l_q.bitc == 4'h7) begin
              l_d.st = LS_ACK_GO;
              unique case (l_q.kind)
                BK_ADDR: begin
                  l_d.rd = byt[0];
                  l_d = issue(l_d, OP_ADDR, l_q.ptr, byt);
                end
                BK_MEM: begin
                  l_d.ptr = byt;
                end
                BK_DATA: begin
                  l_d = issue(l_d, OP_WRITE, l_q.ptr, byt);
                  l_d.ptr = {l_q.ptr[7:1], ~l_q.ptr[0]};
                end
                default: begin
                  l_d.st = LS_IDLE;
                end
              endcase
            end
          end
        end
        LS_ACK_GO: begin
          if (fall) begin
            if (l_q.kind != BK_ADDR || l_q.rsp_ack) begin
              l_d.oe_n = 1'b0;
              l_d.st   = LS_ACK_OUT;
              if (l_q.kind == BK_ADDR && !l_q.rd) begin
                l_d.wr_act = 1'b1;
              end
            end else begin
              l_d.st = LS_IDLE;
            end
          end
        end
        LS_ACK_OUT, LS_LOAD: begin
          if (fall) begin
            if (l_q.rd) begin
              l_d.shift = l_q.rsp_data;
              l_d.oe_n  = l_q.rsp_data[7];
              l_d.bitc  = 4'h0;
              l_d.st    = LS_TX;
            end else begin
              l_d.oe_n  = 1'b1;
              l_d.bitc  = 4'h0;
              l_d.st    = LS_RX;
              l_d.kind  = (l_q.kind == BK_ADDR) ? BK_MEM : BK_DATA;
            end
          end
        end
        LS_TX: begin
          if (fall) begin
            if (l_q.bitc == 4'h7) begin
              l_d.oe_n = 1'b1;
              l_d.st   = LS_ACK_IN;
            end else begin
              l_d.oe_n  = l_q.shift[6];
              l_d.shift = {l_q.shift[6:0], 1'b0};
              l_d.bitc  = l_q.bitc + 4'h1;
            end
          end
        end
        LS_ACK_IN: begin
          if (rise) begin
            l_d.ptr = l_q.ptr + 8'h01;
            if (!sda_s) begin
              l_d = issue(l_d, OP_READ, l_q.ptr + 8'h01, 8'h00);
              l_d.st = LS_LOAD;
            end else begin
              l_d.st = LS_IDLE;
            end
          end
        end
        default: begin
          l_d.st = LS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      l_q       <= '0;
      l_q.st    <= LS_IDLE;
      l_q.kind  <= BK_ADDR;
      l_q.oe_n  <= 1'b1;
      l_q.scl_p <= 1'b1;
      l_q.sda_p <= 1'b1;
      l_q.req_op <= OP_READ;
    end else begin
      l_q <= l_d;
    end
  end

  // memory domain
  dnvr_sync #(.W(2)) u_core_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({l_q.req_tgl, add_sel_i}),
    .q_o   (core_s)
  );

  dnvr_nvm #(
    .T_WR_CYC (T_WR_CYC),
    .T_ST_CYC (T_ST_CYC)
  ) u_nvm (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wr_go_i   (c_q.wr_go),
    .wr_row_i  (c_q.row),
    .wr_mask_i (c_q.wmask),
    .wr_data_i (c_q.pdata),
    .live_o    (live),
    .busy_o    (nv_busy),
    .recall_o  (recalling)
  );

  always_comb begin
    logic       unl;
    logic [7:0] own;
    logic [7:0] a;
    logic [1:0] bit_sel;
    unl = c_q.entry == {live[`DNVR_OFF_KEY_HI], live[`DNVR_OFF_KEY_LO]};
    own = core_s[0] ? live[`DNVR_OFF_BUS_ADDR] : `DNVR_FIXED_ADDR;
    a   = l_q.req_addr;
    bit_sel = a[0] ? 2'b10 : 2'b01;
    c_d = c_q;
    c_d.wr_go = 1'b0;
    // request words are stable: the link holds them until answered
    if (core_s[1] != c_q.req_seen) begin
      c_d.req_seen = core_s[1];
      c_d.ack_tgl  = ~c_q.ack_tgl;
      unique case (l_q.req_op)
        OP_ADDR: begin
          c_d.rsp_ack = (l_q.req_data[7:1] == own[7:1])
                        && !nv_busy && !recalling;
          c_d.rsp_data = rd_byte(a, live, unl);
        end
        OP_READ: begin
          c_d.rsp_data = rd_byte(a, live, unl);
        end
        OP_WRITE: begin
          if (a == `DNVR_OFF_ENTRY_HI) begin
            c_d.entry[15:8] = l_q.req_data;
          end else if (a == `DNVR_OFF_ENTRY_LO) begin
            c_d.entry[7:0] = l_q.req_data;
          end else if (unl && is_nv(a)) begin
            if (c_q.pend == 2'b00 || c_q.row != a[4:1]) begin
              c_d.pend = bit_sel;
              c_d.row  = a[4:1];
            end else begin
              c_d.pend = c_q.pend | bit_sel;
            end
            c_d.pdata[8*a[0] +: 8] = l_q.req_data;
          end
        end
        OP_STOP: begin
          if (c_q.pend != 2'b00 && !nv_busy) begin
            c_d.wr_go = 1'b1;
            c_d.wmask = c_q.pend;
          end
          c_d.pend = 2'b00;
        end
      endcase
    end
    c_d.pos_zero = live[`DNVR_OFF_RES_ZERO];
    c_d.pos_one  = live[`DNVR_OFF_RES_ONE];
    c_d.hiz_zero = recalling
                   || live[`DNVR_OFF_HIZ_CTRL][`DNVR_BIT_FLOAT_ZERO];
    c_d.hiz_one  = recalling
                   || live[`DNVR_OFF_HIZ_CTRL][`DNVR_BIT_FLOAT_ONE];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      c_q          <= '0;
      c_q.entry    <= `DNVR_RST_ENTRY;
      c_q.rsp_data <= `DNVR_RD_NONE;
      c_q.hiz_zero <= 1'b1;
      c_q.hiz_one  <= 1'b1;
    end else begin
      c_q <= c_d;
    end
  end

  // open drain: the pin level is always low, only the enable moves
  assign sda_o            = l_q.lvl;
  assign sda_oe_n_o       = l_q.oe_n;
  assign wiper_zero_pos_o = c_q.pos_zero;
  assign wiper_one_pos_o  = c_q.pos_one;
  assign wiper_zero_hiz_o = c_q.hiz_zero;
  assign wiper_one_hiz_o  = c_q.hiz_one;
endmodule

// ===== dv/dnvr_assertions.sv
// Purpose: port checks of the dual resistor serial slave
// Assumes: bus pins settle high between frames
// Notes:   recall window counted from reset release in clk_i cycles
`timescale 1ns/1ns
module dnvr_assertions #(
  parameter int T_WR_CYC = 2500000,
  parameter int T_ST_CYC = 500000
) (
  // clocks and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       link_clk_i,
  // serial bus
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_n_o,
  input wire logic       add_sel_i,
  // resistor controls
  input wire logic [7:0] wiper_zero_pos_o,
  input wire logic [7:0] wiper_one_pos_o,
  input wire logic       wiper_zero_hiz_o,
  input wire logic       wiper_one_hiz_o
);
  logic [31:0] up_q;
  logic        ready;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      up_q <= 32'h0;
    end else if (up_q != 32'hFFFFFFFF) begin
      up_q <= up_q + 32'h1;
    end
  end
  // margin covers the one-cycle output lag after recall
  assign ready = up_q > 32'(T_ST_CYC + 8);
  property p_recall_hiz;
    @(posedge clk_i) disable iff (rst_i)
      up_q < 32'(T_ST_CYC) |-> wiper_zero_hiz_o && wiper_one_hiz_o;
  endproperty
  a_recall_hiz: assert property (p_recall_hiz)
    else $error("resistor not floating during recall");
  property p_recall_nack;
    @(posedge clk_i) disable iff (rst_i)
      up_q < 32'(T_ST_CYC) |-> sda_oe_n_o;
  endproperty
  a_recall_nack: assert property (p_recall_nack)
    else $error("bus driven during recall");
  property p_pos_idle;
    @(posedge clk_i) disable iff (rst_i)
      ready && $changed({wiper_zero_pos_o, wiper_one_pos_o})
      |-> scl_i && sda_i;
  endproperty
  a_pos_idle: assert property (p_pos_idle)
    else $error("setting changed inside a frame");
  property p_hiz_idle;
    @(posedge clk_i) disable iff (rst_i)
      ready && $changed({wiper_zero_hiz_o, wiper_one_hiz_o})
      |-> scl_i && sda_i;
  endproperty
  a_hiz_idle: assert property (p_hiz_idle)
    else $error("float bit changed inside a frame");
  property p_od_low;
    @(posedge link_clk_i) disable iff (rst_i) sda_o == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("data output not open drain");
  property p_change_low;
    @(posedge link_clk_i) disable iff (rst_i)
      $changed(sda_oe_n_o) |-> !scl_i;
  endproperty
  a_change_low: assert property (p_change_low)
    else $error("data drive changed with clock high");
  property p_ack_hold;
    @(posedge link_clk_i) disable iff (rst_i)
      $fell(sda_oe_n_o) |-> !sda_oe_n_o [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("low bit released too early");
  property p_start_quiet;
    @(posedge link_clk_i) disable iff (rst_i)
      scl_i && $past(scl_i) && $fell(sda_i) |-> sda_oe_n_o [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet)
    else $error("bus driven right after start");
  c_ack: cover property (@(posedge link_clk_i) $fell(sda_oe_n_o));
  c_pos: cover property (@(posedge clk_i) ready && $changed(wiper_zero_pos_o));
  c_hiz: cover property (@(posedge clk_i) ready && $rose(wiper_one_hiz_o));
endmodule
bind dnvr_top dnvr_assertions #(
  .T_WR_CYC(T_WR_CYC),
  .T_ST_CYC(T_ST_CYC)
) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .add_sel_i(add_sel_i),
  .wiper_zero_pos_o(wiper_zero_pos_o), .wiper_one_pos_o(wiper_one_pos_o),
  .wiper_zero_hiz_o(wiper_zero_hiz_o), .wiper_one_hiz_o(wiper_one_hiz_o)
);

// ===== dv/dnvr_master.sv
// Purpose: behavioural serial bus master for the bench
// Assumes: wire level fed back on sda_i, pulled high when released
// Notes:   clock held high between frames, no stretching
`timescale 1ns/1ns
module dnvr_master #(
  parameter int Q = 24
) (
  // clock
  input  wire logic clk_i,
  // bus
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_n_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  task automatic wq(input int n);
    repeat (n * Q) @(posedge clk_i);
  endtask
  // data moves mid-low, read back at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    scl_o <= 1'b0;
    wq(1);
    sda_oe_n_o <= b;
    wq(1);
    scl_o <= 1'b1;
    wq(2);
    r = sda_i;
  endtask
  task automatic start();
    scl_o <= 1'b0;
    wq(1);
    sda_oe_n_o <= 1'b1;
    wq(1);
    scl_o <= 1'b1;
    wq(2);
    sda_oe_n_o <= 1'b0;
    wq(2);
  endtask
  task automatic stop();
    scl_o <= 1'b0;
    wq(1);
    sda_oe_n_o <= 1'b0;
    wq(1);
    scl_o <= 1'b1;
    wq(2);
    sda_oe_n_o <= 1'b1;
    wq(2);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nack);
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// ===== dv/dnvr_top_bench.sv
// Purpose: self-checking bench of the dual resistor serial slave
// Assumes: shortened recall and write times
// Notes:   protection is left armed by the last test
`timescale 1ns/1ns
module dnvr_top_bench;
  localparam int TW = 1200;
  localparam logic [7:0] RV [8] = '{8'hA0, 8'h00, 8'h7F, 8'h7F,
                                    8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic       clk = 1'b0;
  logic       lclk = 1'b0;
  logic       rst = 1'b1;
  logic       sel = 1'b0;
  logic       scl;
  logic       m_oe_n;
  logic       oe_n;
  logic [7:0] pos0;
  logic [7:0] pos1;
  logic       hz0;
  logic       hz1;
  logic [7:0] rq [8];
  int         n_errors = 0;
  int         compares = 0;
  int         cyc = 0;
  wire        sda = m_oe_n & oe_n;
  always #2 clk = ~clk;
  always begin
    #7 lclk = 1'b1;
    #8 lclk = 1'b0;
  end
  dnvr_top #(.T_WR_CYC(TW), .T_ST_CYC(TW)) dut (
    .clk_i(clk), .rst_i(rst), .link_clk_i(lclk), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe_n_o(oe_n), .add_sel_i(sel),
    .wiper_zero_pos_o(pos0), .wiper_one_pos_o(pos1),
    .wiper_zero_hiz_o(hz0), .wiper_one_hiz_o(hz1));
  dnvr_master #(.Q(24)) m (
    .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [7:0] s, e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic do_rst();
    rst <= 1'b1;
    w(10);
    rst <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] sa, loc, input logic [15:0] d,
                    input int n);
    logic a;
    logic na;
    m.start();
    m.wbyte(sa, na);
    m.wbyte(loc, a);
    na |= a;
    for (int k = n - 1; k >= 0; k--) begin
      m.wbyte(d[8*k +: 8], a);
      na |= a;
    end
    m.stop();
    chk("write ack", {7'h00, na}, 8'h00);
    w(TW + 50);
  endtask
  task automatic rd(input logic [7:0] sa, loc, input int n);
    logic a;
    logic na;
    m.start();
    m.wbyte(sa, na);
    m.wbyte(loc, a);
    na |= a;
    m.start();
    m.wbyte(sa | 8'h01, a);
    na |= a;
    for (int k = 0; k < n; k++) m.rbyte(k == n - 1, rq[k]);
    m.stop();
    chk("read ack", {7'h00, na}, 8'h00);
  endtask
  task automatic t_power();
    logic a;
    do_rst();
    chk("hiz recall", {6'h00, hz1, hz0}, 8'h03);
    m.start();
    m.wbyte(8'hA2, a);
    m.stop();
    chk("recall nack", {7'h00, a}, 8'h01);
    w(TW);
    chk("pos0 stored", pos0, 8'h7F);
    chk("hiz stored", {6'h00, hz1, hz0}, 8'h00);
    rd(8'hA2, 8'h00, 8);
    for (int k = 0; k < 8; k++) chk("reset value", rq[k], RV[k]);
    $display("test power done");
  endtask
  task automatic t_write();
    logic a;
    logic [31:0] b;
    wr(8'hA2, 8'h02, 16'h00FF, 2);
    chk("pos0 min", pos0, 8'h00);
    chk("pos1 max", pos1, 8'hFF);
    b = 32'h02112233;
    m.start();
    m.wbyte(8'hA2, a);
    for (int k = 3; k >= 0; k--) m.wbyte(b[8*k +: 8], a);
    chk("pos0 before stop", pos0, 8'h00);
    m.stop();
    m.start();
    m.wbyte(8'hA2, a);
    m.stop();
    chk("busy nack", {7'h00, a}, 8'h01);
    w(TW);
    chk("pos0 wrap", pos0, 8'h33);
    chk("pos1 wrap", pos1, 8'h22);
    $display("test write done");
  endtask
  task automatic t_hiz();
    logic [7:0] v [3];
    v = '{8'h01, 8'h02, 8'h00};
    for (int k = 0; k < 3; k++) begin
      wr(8'hA2, 8'h01, {8'h00, v[k]}, 1);
      chk("float bits", {6'h00, hz1, hz0}, v[k]);
    end
    chk("pos0 restored", pos0, 8'h33);
    $display("test hiz done");
  endtask
  task automatic t_addr();
    logic a;
    logic na;
    wr(8'hA2, 8'h08, 16'h005A, 1);
    rd(8'hA2, 8'h08, 1);
    chk("gap read", rq[0], 8'hFF);
    sel <= 1'b1;
    wr(8'hA0, 8'h10, 16'h00C3, 1);
    wr(8'hA0, 8'h00, 16'h00B5, 1);
    rd(8'hB4, 8'h10, 1);
    chk("stored address", rq[0], 8'hC3);
    sel <= 1'b0;
    m.start();
    m.wbyte(8'hA0, a);
    m.wbyte(8'hA2, na);
    m.stop();
    chk("foreign address", {7'h00, a}, 8'h01);
    chk("ignored to start", {7'h00, na}, 8'h01);
    $display("test address done");
  endtask
  task automatic t_lock();
    wr(8'hA2, 8'h06, 16'h1234, 2);
    wr(8'hA2, 8'h02, 16'h0055, 1);
    chk("locked pos0", pos0, 8'h33);
    rd(8'hA2, 8'h02, 1);
    chk("locked read", rq[0], 8'h33);
    wr(8'hA2, 8'h04, 16'h1234, 2);
    wr(8'hA2, 8'h02, 16'h0055, 1);
    chk("unlocked pos0", pos0, 8'h55);
    rd(8'hA2, 8'h06, 2);
    chk("key high read", rq[0], 8'h12);
    chk("key low read", rq[1], 8'h34);
    do_rst();
    w(TW + 50);
    wr(8'hA2, 8'h02, 16'h0066, 1);
    chk("relocked pos0", pos0, 8'h55);
    $display("test lock done");
  endtask
  initial begin
    t_power();
    t_write();
    t_hiz();
    t_addr();
    t_lock();
    end_sim();
  end
endmodule
